// file: rtl/lia_pkg.sv
`default_nettype none

package lia_pkg;

  // ----------------------------------------------------------------------
  // Operation and operand-form encodings
  // ----------------------------------------------------------------------

  // Operation selected by the decoder for this datapath.
  typedef enum logic [3:0] {
    LIA_OP_AND     = 4'h0, // logic_and_op
    LIA_OP_OR      = 4'h1, // logic_or_op
    LIA_OP_XOR     = 4'h2, // logic_xor_op
    LIA_OP_ZERO    = 4'h3, // acc_zero_op
    LIA_OP_INVERT  = 4'h4, // acc_invert_op
    LIA_OP_ROL     = 4'h5, // rotate_left_op
    LIA_OP_ROLC    = 4'h6, // rotate_left_carry_op
    LIA_OP_ROR     = 4'h7, // rotate_right_op
    LIA_OP_RORC    = 4'h8, // rotate_right_carry_op
    LIA_OP_SWAP    = 4'h9  // Nibble swap.
  } lia_op_t;

  // Operand form of a two-operand logic operation.
  typedef enum logic [2:0] {
    LIA_FORM_REG     = 3'h0, // Working register into accumulator.
    LIA_FORM_DIRECT  = 3'h1, // Direct byte into accumulator.
    LIA_FORM_INDIR   = 3'h2, // Indirect RAM into accumulator.
    LIA_FORM_IMM     = 3'h3, // Immediate into accumulator.
    LIA_FORM_DIR_ACC = 3'h4, // Accumulator into direct byte.
    LIA_FORM_DIR_IMM = 3'h5  // Immediate into direct byte.
  } lia_form_t;

  // Sequencer states, Gray coded along idle, fetch, store.
  typedef enum logic [1:0] {
    LIA_ST_IDLE  = 2'h0,
    LIA_ST_FETCH = 2'h1,
    LIA_ST_STORE = 2'h3
  } lia_state_t;

  // ----------------------------------------------------------------------
  // Instruction lengths in bytes
  // ----------------------------------------------------------------------

  localparam logic [1:0] LIA_LEN_REG     = 2'h1;
  localparam logic [1:0] LIA_LEN_DIRECT  = 2'h2;
  localparam logic [1:0] LIA_LEN_INDIR   = 2'h1;
  localparam logic [1:0] LIA_LEN_IMM     = 2'h2;
  localparam logic [1:0] LIA_LEN_DIR_ACC = 2'h2;
  localparam logic [1:0] LIA_LEN_DIR_IMM = 2'h3;
  localparam logic [1:0] LIA_LEN_ACC     = 2'h1;

  // Cycle counts per form, kept for reference by the bench.
  localparam int LIA_CYC_REG     = 1;
  localparam int LIA_CYC_DIRECT  = 2;
  localparam int LIA_CYC_INDIR   = 2;
  localparam int LIA_CYC_IMM     = 2;
  localparam int LIA_CYC_DIR_ACC = 3;
  localparam int LIA_CYC_DIR_IMM = 3;
  localparam int LIA_CYC_ACC     = 1;

  // Nibble width used by the swap, and the accumulator reset value.
  localparam int LIA_NIB_W       = 4;
  localparam logic [7:0] LIA_ACC_RESET = 8'h00;

endpackage

`default_nettype wire

// file: rtl/lia_logic_alu.sv
`default_nettype none

// Overview of operation
// [RULE1] AND, OR and XOR act on each bit position alone, with no carry between bits.
// [RULE2] Working register combined into the accumulator takes one byte and one cycle.
// [RULE3] Direct byte combined into the accumulator takes two bytes and two cycles.
// [RULE4] Indirect RAM combined into the accumulator takes one byte and two cycles.
// [RULE5] Immediate combined into the accumulator takes two bytes and two cycles.
// [RULE6] Accumulator combined into a direct byte writes it back, two bytes, three cycles.
// [RULE7] Immediate combined into a direct byte writes it back, three bytes, three cycles.
// [RULE8] Left rotate exists plain and through carry, one byte and one cycle each.
// [RULE9] Right rotate exists plain and through carry, one byte and one cycle each.
// [RULE10] Nibble swap exchanges the accumulator halves in one byte and one cycle.
// [RULE11] Clear zeroes and complement inverts the accumulator, one byte and one cycle each.
module lia_logic_alu
  import lia_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              clkEn,
  input  wire logic              issueValid,
  input  wire logic [3:0]        issueOp,
  input  wire logic [2:0]        issueForm,
  input  wire logic [ADDR_W-1:0] issueAddr,
  input  wire logic [7:0]        issueImm,
  input  wire logic [7:0]        workReg,
  input  wire logic [ADDR_W-1:0] indexReg,
  input  wire logic [7:0]        memRdData,
  input  wire logic              carryLoad,
  input  wire logic              carryLoadData,
  output logic                   ready_q,
  output logic                   done_q,
  output logic [1:0]             instrLen_q,
  output logic [7:0]             acc_q,
  output logic                   carry_q,
  output logic                   memRd_q,
  output logic                   memWr_q,
  output logic [ADDR_W-1:0]      memAddr_q,
  output logic [7:0]             memWrData_q
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------

  // The direct and indirect spaces need at least a byte of address.
  if (ADDR_W < 8)
  begin : gAddrCheck
    $error("lia_logic_alu: ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Bitwise operation; every output bit looks only at its own two inputs.
  function automatic logic [7:0] logicByte(input logic [3:0] op,
                                           input logic [7:0] a,
                                           input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      case (op)
        LIA_OP_AND: r[i] = a[i] & b[i]; // [RULE1]
        LIA_OP_OR:  r[i] = a[i] | b[i]; // [RULE1]
        LIA_OP_XOR: r[i] = a[i] ^ b[i]; // [RULE1]
        default:    r[i] = a[i];
      endcase
    end
    return r;
  endfunction

  // True for the three two-operand operations.
  function automatic logic isBinary(input logic [3:0] op);
    return (op == LIA_OP_AND) || (op == LIA_OP_OR) || (op == LIA_OP_XOR);
  endfunction

  // True for forms that read a byte from the data space.
  function automatic logic readsMem(input logic [2:0] form);
    return (form == LIA_FORM_DIRECT) || (form == LIA_FORM_INDIR) ||
           (form == LIA_FORM_DIR_ACC) || (form == LIA_FORM_DIR_IMM);
  endfunction

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------

  logic rstMeta_q;
  logic rstn_q;

  // Release is synchronised so that no flop leaves reset on a skewed edge.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta_q <= 1'b0;
      rstn_q    <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstn_q    <= rstMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Issue decode
  // ----------------------------------------------------------------------

  lia_state_t state_q;
  logic [3:0] op_q;
  logic [2:0] form_q;
  logic [7:0] imm_q;
  logic       take;
  logic       binIssue;
  logic       multi;
  logic [1:0] len;
  logic [7:0] fetchRes;

  assign take     = clkEn && issueValid && ready_q;
  assign binIssue = isBinary(issueOp);
  // Of a binary operation, only the register form and the undefined forms above LIA_FORM_DIR_IMM complete at issue.
  assign multi    = binIssue && (issueForm != LIA_FORM_REG) && (issueForm <= LIA_FORM_DIR_IMM);

  // Byte length reported for program-counter advance.
  always_comb
  begin
    len = LIA_LEN_ACC; // [RULE8] [RULE9] [RULE10] [RULE11]
    if (binIssue)
    begin
      case (issueForm)
        LIA_FORM_REG:     len = LIA_LEN_REG;     // [RULE2]
        LIA_FORM_DIRECT:  len = LIA_LEN_DIRECT;  // [RULE3]
        LIA_FORM_INDIR:   len = LIA_LEN_INDIR;   // [RULE4]
        LIA_FORM_IMM:     len = LIA_LEN_IMM;     // [RULE5]
        LIA_FORM_DIR_ACC: len = LIA_LEN_DIR_ACC; // [RULE6]
        LIA_FORM_DIR_IMM: len = LIA_LEN_DIR_IMM; // [RULE7]
        default:          len = LIA_LEN_ACC;
      endcase
    end
  end

  // Result of the fetch cycle: memory or immediate meets the second operand.
  always_comb
  begin
    case (form_q)
      LIA_FORM_IMM:     fetchRes = logicByte(op_q, acc_q, imm_q);
      LIA_FORM_DIR_ACC: fetchRes = logicByte(op_q, memRdData, acc_q);
      LIA_FORM_DIR_IMM: fetchRes = logicByte(op_q, memRdData, imm_q);
      default:          fetchRes = logicByte(op_q, acc_q, memRdData);
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------

  // Fetch is the second cycle; forms that write memory add a store cycle.
  always_ff @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      state_q <= LIA_ST_IDLE;
      ready_q <= 1'b0;
      op_q    <= 4'h0;
      form_q  <= 3'h0;
      imm_q   <= 8'h00;
    end
    else if (clkEn)
    begin
      case (state_q)
        LIA_ST_IDLE:
        begin
          ready_q <= 1'b1;
          if (take && multi)
          begin
            state_q <= LIA_ST_FETCH;
            ready_q <= 1'b0;
            op_q    <= issueOp;
            form_q  <= issueForm;
            imm_q   <= issueImm;
          end
        end
        LIA_ST_FETCH:
        begin
          if ((form_q == LIA_FORM_DIR_ACC) || (form_q == LIA_FORM_DIR_IMM))
          begin
            state_q <= LIA_ST_STORE; // [RULE6] [RULE7]
          end
          else
          begin
            state_q <= LIA_ST_IDLE; // [RULE3] [RULE4] [RULE5]
            ready_q <= 1'b1;
          end
        end
        LIA_ST_STORE:
        begin
          state_q <= LIA_ST_IDLE;
          ready_q <= 1'b1;
        end
        default:
        begin
          state_q <= LIA_ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Accumulator and carry
  // ----------------------------------------------------------------------

  // Single-cycle forms commit at the issue edge; fetch forms into the accumulator one edge later.
  always_ff @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      acc_q   <= LIA_ACC_RESET;
      carry_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (carryLoad)
      begin
        carry_q <= carryLoadData;
      end
      if (take && !multi)
      begin
        case (issueOp)
          LIA_OP_AND, LIA_OP_OR, LIA_OP_XOR:
            acc_q <= logicByte(issueOp, acc_q, workReg); // [RULE2]
          LIA_OP_ZERO:   acc_q <= 8'h00;  // [RULE11]
          LIA_OP_INVERT: acc_q <= ~acc_q; // [RULE11]
          LIA_OP_ROL:    acc_q <= {acc_q[6:0], acc_q[7]}; // [RULE8]
          LIA_OP_ROLC:
          begin
            acc_q   <= {acc_q[6:0], carry_q}; // [RULE8]
            carry_q <= acc_q[7];
          end
          LIA_OP_ROR:    acc_q <= {acc_q[0], acc_q[7:1]}; // [RULE9]
          LIA_OP_RORC:
          begin
            acc_q   <= {carry_q, acc_q[7:1]}; // [RULE9]
            carry_q <= acc_q[0];
          end
          LIA_OP_SWAP:
            acc_q <= {acc_q[LIA_NIB_W-1:0], acc_q[7:LIA_NIB_W]}; // [RULE10]
          default:       acc_q <= acc_q;
        endcase
      end
      else if ((state_q == LIA_ST_FETCH) && (form_q <= LIA_FORM_IMM))
      begin
        acc_q <= fetchRes; // [RULE3] [RULE4] [RULE5]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data-space port
  // ----------------------------------------------------------------------

  // Reads are asserted in the fetch cycle; memory answers in that cycle.
  always_ff @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      memRd_q     <= 1'b0;
      memWr_q     <= 1'b0;
      memAddr_q   <= '0;
      memWrData_q <= 8'h00;
    end
    else if (clkEn)
    begin
      memRd_q <= take && multi && readsMem(issueForm);
      memWr_q <= (state_q == LIA_ST_FETCH) && (form_q >= LIA_FORM_DIR_ACC); // [RULE6] [RULE7]
      if (take && multi)
      begin
        memAddr_q <= (issueForm == LIA_FORM_INDIR) ? indexReg : issueAddr; // [RULE4]
      end
      if (state_q == LIA_ST_FETCH)
      begin
        memWrData_q <= fetchRes; // [RULE6] [RULE7]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Completion
  // ----------------------------------------------------------------------

  // Done pulses in the first cycle after the last cycle of the instruction.
  always_ff @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      done_q     <= 1'b0;
      instrLen_q <= 2'h0;
    end
    else if (clkEn)
    begin
      done_q <= (take && !multi) || (state_q == LIA_ST_STORE) ||
                ((state_q == LIA_ST_FETCH) && (form_q <= LIA_FORM_IMM));
      if (take)
      begin
        instrLen_q <= len;
      end
    end
  end

endmodule // lia_logic_alu

`default_nettype wire

// file: verif/lia_logic_alu_assertions.sv
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module lia_logic_alu_assertions
  import lia_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              clkEn,
  input wire logic              issueValid,
  input wire logic [3:0]        issueOp,
  input wire logic [2:0]        issueForm,
  input wire logic [ADDR_W-1:0] issueAddr,
  input wire logic [7:0]        issueImm,
  input wire logic [7:0]        workReg,
  input wire logic [ADDR_W-1:0] indexReg,
  input wire logic [7:0]        memRdData,
  input wire logic              carryLoad,
  input wire logic              ready_q,
  input wire logic              done_q,
  input wire logic [1:0]        instrLen_q,
  input wire logic [7:0]        acc_q,
  input wire logic              carry_q,
  input wire logic              memRd_q,
  input wire logic              memWr_q,
  input wire logic [ADDR_W-1:0] memAddr_q
  ,input wire logic [7:0]       memWrData_q
);
  // Two-operand result, one bit position at a time.
  function automatic logic [7:0] lf(input logic [3:0] op, input logic [7:0] a,
                                    input logic [7:0] b);
    return (op == 4'h0) ? (a & b) : (op == 4'h1) ? (a | b) : (a ^ b);
  endfunction
  // Accumulator-only result as {carry, acc}.
  function automatic logic [8:0] un(input logic [3:0] op, input logic [7:0] a, input logic c);
    case (op)
      4'h3: return {c, 8'h00};
      4'h4: return {c, ~a};
      4'h5: return {c, a[6:0], a[7]};
      4'h6: return {a, c};
      4'h7: return {c, a[0], a[7:1]};
      4'h8: return {a[0], c, a[7:1]};
      default: return {c, a[3:0], a[7:4]};
    endcase
  endfunction
  // Byte count that each form must report.
  function automatic logic [1:0] len(input logic [3:0] op, input logic [2:0] f);
    if (op > 4'h2 || f == 3'h0 || f == 3'h2 || f > 3'h5)
      return LIA_LEN_REG;
    return (f == 3'h5) ? LIA_LEN_DIR_IMM : LIA_LEN_DIRECT;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // A taken request; carry loads are kept out to keep the carry checks simple.
  wire logic take = clkEn && issueValid && ready_q;
  wire logic lg   = take && (issueOp < 4'h3);
  wire logic un1  = take && !carryLoad;
  sequence rdPhase;
    memRd_q && !ready_q && !done_q;
  endsequence
  sequence wrPhase;
    memWr_q && $stable(acc_q) && $stable(memAddr_q);
  endsequence

  regDone_a: assert property (take && (issueOp > 4'h2 || issueForm == 3'h0)
    |=> done_q && ready_q) else $error("one-cycle op late");
  regLogic_a: assert property (lg && issueForm == 3'h0
    |=> acc_q == lf($past(issueOp), $past(acc_q), $past(workReg))) else $error("reg op");
  directRead_a: assert property (lg && issueForm == 3'h1 |=> rdPhase
    ##0 memAddr_q == $past(issueAddr) ##1 done_q
    && acc_q == lf($past(issueOp, 2), $past(acc_q, 2), $past(memRdData))) else $error("direct");
  indirRead_a: assert property (lg && issueForm == 3'h2 |=> rdPhase
    ##0 memAddr_q == $past(indexReg) ##1 done_q
    && acc_q == lf($past(issueOp, 2), $past(acc_q, 2), $past(memRdData))) else $error("indir");
  immTwo_a: assert property (lg && issueForm == 3'h3
    |=> !memRd_q && !ready_q && !done_q ##1 done_q
    && acc_q == lf($past(issueOp, 2), $past(acc_q, 2), $past(issueImm, 2))) else $error("imm");
  storeBack_a: assert property (lg && (issueForm == 3'h4 || issueForm == 3'h5)
    |=> rdPhase ##0 memAddr_q == $past(issueAddr) ##1 wrPhase
    ##0 memWrData_q == lf($past(issueOp, 2), $past(memRdData),
    ($past(issueForm, 2) == 3'h4) ? $past(acc_q, 2) : $past(issueImm, 2))
    ##1 done_q && ready_q && !memWr_q) else $error("store back");
  lenCount_a: assert property (take
    |=> instrLen_q == len($past(issueOp), $past(issueForm))) else $error("length");
  rotateAcc_a: assert property (un1 && issueOp > 4'h4 && issueOp < 4'h9
    |=> {carry_q, acc_q} == un($past(issueOp), $past(acc_q), $past(carry_q))) else $error("rot");
  accMisc_a: assert property (un1 && (issueOp inside {4'h3, 4'h4, 4'h9})
    |=> {1'b0, acc_q} == un($past(issueOp), $past(acc_q), 1'b0)) else $error("clr cpl swap");
endmodule // lia_logic_alu_assertions

bind lia_logic_alu lia_logic_alu_assertions #(.ADDR_W(ADDR_W)) u_lia_logic_alu_assertions (
  .clk(clk), .resetn(resetn), .clkEn(clkEn), .issueValid(issueValid), .issueOp(issueOp),
  .issueForm(issueForm), .issueAddr(issueAddr), .issueImm(issueImm), .workReg(workReg),
  .indexReg(indexReg), .memRdData(memRdData), .carryLoad(carryLoad), .ready_q(ready_q),
  .done_q(done_q), .instrLen_q(instrLen_q), .acc_q(acc_q), .carry_q(carry_q),
  .memRd_q(memRd_q), .memWr_q(memWr_q), .memAddr_q(memAddr_q), .memWrData_q(memWrData_q));
`default_nettype wire

// file: verif/lia_logic_alu_tb_top.sv
`default_nettype none
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module lia_logic_alu_tb_top
  import lia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       issueValid = 1'b0;
  logic [3:0] issueOp = 4'h0;
  logic [2:0] issueForm = 3'h0;
  logic [7:0] issueAddr = 8'h00, issueImm = 8'h00, workReg = 8'h00, indexReg = 8'h00;
  logic [7:0] memVal = 8'h00, memRdData, acc_q, memAddr_q, memWrData_q, expAcc;
  logic       carryLoad = 1'b0, carryLoadData = 1'b0, expC;
  logic       clkEn = 1'b1;
  logic       ready_q, done_q, carry_q, memRd_q, memWr_q;
  logic [1:0] instrLen_q;
  int         miscompares = 0, check_count = 0, cycles = 0;

  lia_logic_alu u_lia_logic_alu (
    .clk(clk), .resetn(resetn), .clkEn(clkEn), .issueValid(issueValid), .issueOp(issueOp),
    .issueForm(issueForm), .issueAddr(issueAddr), .issueImm(issueImm), .workReg(workReg),
    .indexReg(indexReg), .memRdData(memRdData), .carryLoad(carryLoad),
    .carryLoadData(carryLoadData), .ready_q(ready_q), .done_q(done_q),
    .instrLen_q(instrLen_q), .acc_q(acc_q), .carry_q(carry_q), .memRd_q(memRd_q),
    .memWr_q(memWr_q), .memAddr_q(memAddr_q), .memWrData_q(memWrData_q));

  always #10 clk = ~clk;
  // Read data is only good in the strobe cycle; otherwise it shows the inverse.
  assign memRdData = memRd_q ? memVal : ~memVal;
  // Cycle ceiling, far above the roughly 120 cycles the run needs.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Issues one request, counts cycles to done and checks the memory side.
  task automatic run(input int op, input int f, input int cyc, output logic [7:0] wd);
    int n = 0;
    @(posedge clk);
    #1;
    issueOp = op[3:0];
    issueForm = f[2:0];
    issueValid = 1'b1;
    do
    begin
      @(posedge clk);
      #1;
      issueValid = 1'b0;
      n++;
      if (memRd_q === 1'b1)
        chk(memAddr_q, (f == 2) ? indexReg : issueAddr, "rd addr");
      if (memWr_q === 1'b1)
      begin
        chk(memAddr_q, issueAddr, "wr addr");
        wd = memWrData_q;
      end
    end while (done_q !== 1'b1 && n < 8);
    chk(n[7:0], cyc[7:0], "cycles");
  endtask

  function automatic logic [7:0] lf(input int op, input logic [7:0] a, input logic [7:0] b);
    return (op == 0) ? (a & b) : (op == 1) ? (a | b) : (a ^ b);
  endfunction

  // Every two-operand op in every form, XOR first so the accumulator is busy.
  task automatic t_logic();
    int cycT[6] = '{LIA_CYC_REG, LIA_CYC_DIRECT, LIA_CYC_INDIR, LIA_CYC_IMM,
                    LIA_CYC_DIR_ACC, LIA_CYC_DIR_IMM};
    logic [1:0] lenT[6] = '{LIA_LEN_REG, LIA_LEN_DIRECT, LIA_LEN_INDIR, LIA_LEN_IMM,
                            LIA_LEN_DIR_ACC, LIA_LEN_DIR_IMM};
    logic [7:0] b;
    logic [7:0] wd;
    for (int op = 2; op >= 0; op--)
      for (int f = 0; f < 6; f++)
      begin
        workReg = 8'h5a + f[7:0];
        memVal = 8'h3c ^ {f[3:0], 4'h9};
        issueImm = 8'hc6 - op[7:0];
        issueAddr = 8'h40 + f[7:0];
        indexReg = 8'h81 + f[7:0];
        b = (f == 0) ? workReg : (f == 1 || f == 2) ? memVal : issueImm;
        run(op, f, cycT[f], wd);
        if (f < 4)
          expAcc = lf(op, expAcc, b);
        else
          chk(wd, lf(op, memVal, (f == 4) ? expAcc : issueImm), "wr data");
        chk(acc_q, expAcc, "acc");
        chk({6'h00, instrLen_q}, {6'h00, lenT[f]}, "len");
      end
  endtask

  // Clear, complement, rotates and swap, once with each carry value.
  task automatic t_unary();
    logic [7:0] wd;
    logic [8:0] r;
    for (int k = 0; k < 2; k++)
    begin
      issueImm = 8'h96 + k[7:0];
      run(2, 3, LIA_CYC_IMM, wd);
      expAcc = expAcc ^ issueImm;
      carryLoad = 1'b1;
      carryLoadData = k[0];
      @(posedge clk);
      #1;
      carryLoad = 1'b0;
      expC = k[0];
      for (int op = 9; op >= 3; op--)
      begin
        case (op)
          3: r = {expC, 8'h00};
          4: r = {expC, ~expAcc};
          5: r = {expC, expAcc[6:0], expAcc[7]};
          6: r = {expAcc, expC};
          7: r = {expC, expAcc[0], expAcc[7:1]};
          8: r = {expAcc[0], expC, expAcc[7:1]};
          default: r = {expC, expAcc[3:0], expAcc[7:4]};
        endcase
        {expC, expAcc} = r;
        run(op, 0, LIA_CYC_ACC, wd);
        chk(acc_q, expAcc, "acc");
        chk({7'h00, carry_q}, {7'h00, expC}, "carry");
        chk({6'h00, instrLen_q}, {6'h00, LIA_LEN_ACC}, "len");
      end
    end
  endtask

  // Clock enable low freezes everything; a request offered meanwhile waits for it.
  task automatic t_freeze();
    logic [7:0] accHold;
    @(posedge clk);
    #1;
    accHold = acc_q;
    clkEn = 1'b0;
    issueOp = LIA_OP_INVERT;
    issueForm = LIA_FORM_REG;
    issueValid = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(acc_q, accHold, "frozen acc");
    chk({7'h00, done_q}, 8'h00, "frozen done");
    clkEn = 1'b1;
    @(posedge clk);
    #1;
    issueValid = 1'b0;
    expAcc = ~accHold;
    chk(acc_q, expAcc, "acc after freeze");
    chk({7'h00, done_q}, 8'h01, "done after freeze");
  endtask

  // Main sequence: reset for 20 cycles, wait a fixed 4 cycles for ready, then the scenarios.
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(acc_q, LIA_ACC_RESET, "reset acc");
    expAcc = LIA_ACC_RESET;
    t_logic();
    t_unary();
    t_freeze();
    final_report();
  end
endmodule // lia_logic_alu_tb_top
`default_nettype wire
